/* File: rtl/nau_pkg.sv */
// Constants shared by the nibble arithmetic unit
package nau_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int ACC_W = 4;
  localparam int PTR_W = 7;
  localparam int DIGIT_W = 4;
  localparam int ROW_W_LARGE = 3;
  localparam int ROW_W_SMALL = 2;
  localparam int RAM_DEPTH = 128;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [PTR_W-1:0] PTR_MASK_LARGE = 7'h7F;
  localparam logic [PTR_W-1:0] PTR_MASK_SMALL = 7'h3F;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_ADD_CARRY_SKIP = 8'h30;
  localparam logic [7:0] OP_ADD = 8'h31;
  localparam logic [7:0] OP_ADD_TEN = 8'h4A;
  localparam logic [3:0] OP_ADD_IMM_HI = 4'h5;
  localparam logic [7:0] OP_COMP_ADD_CARRY = 8'h10;
  localparam logic [7:0] OP_CLEAR_ACC = 8'h00;
  localparam logic [7:0] OP_COMP = 8'h40;
  localparam logic [7:0] OP_NOP = 8'h44;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'h32;
  localparam logic [7:0] OP_CARRY_SET = 8'h22;
  localparam logic [7:0] OP_XOR = 8'h02;
  localparam logic [ACC_W-1:0] ADD_TEN_VALUE = 4'hA;
  // ==========================================================
  // Register byte offsets and status bits
  localparam logic [ADDR_W-1:0] REG_OPCODE = 5'h00;
  localparam logic [ADDR_W-1:0] REG_ACC = 5'h04;
  localparam logic [ADDR_W-1:0] REG_CARRY = 5'h08;
  localparam logic [ADDR_W-1:0] REG_PTR = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_RAM = 5'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h14;
  localparam int ST_SKIP_BIT = 0;
  localparam int ST_BADOP_BIT = 1;
  // ==========================================================
  // Reset values
  localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_RST = 7'h00;
  localparam logic [7:0] OPCODE_RST = 8'h44;
endpackage : nau_pkg

/* File: rtl/nau_core_if.sv */
// Interface joining the core to its ALU and operand RAM
`timescale 1ns/100ps
interface nau_core_if;
  import nau_pkg::*;
  logic [7:0] opcode;
  logic [ACC_W-1:0] acc;
  logic carry;
  logic [ACC_W-1:0] mem;
  logic [ACC_W-1:0] res_acc;
  logic res_carry;
  logic skip;
  logic known;
  logic [PTR_W-1:0] ram_idx;
  logic ram_we;
  logic [ACC_W-1:0] ram_wdata;
  logic [ACC_W-1:0] ram_rdata;
  modport core (output opcode, acc, carry, mem, ram_idx, ram_we, ram_wdata,
    input res_acc, res_carry, skip, known, ram_rdata);
  modport alu (input opcode, acc, carry, mem, output res_acc, res_carry, skip, known);
  modport ram (input ram_idx, ram_we, ram_wdata, output ram_rdata);
endinterface : nau_core_if

/* File: rtl/nau_alu.sv */
// Decode and arithmetic for the accumulator opcodes
`timescale 1ns/100ps
module nau_alu (
  // Operands in, results out
  nau_core_if.alu alu_if
);
  import nau_pkg::*;
  logic [ACC_W-1:0] imm;
  logic [ACC_W:0] sum_add_cs;
  logic [ACC_W:0] sum_comp_cs;
  logic [ACC_W:0] sum_imm;
  logic is_add_cs;
  logic is_comp_cs;
  logic is_imm;
  assign imm = alu_if.opcode[ACC_W-1:0];
  assign is_add_cs = alu_if.opcode == OP_ADD_CARRY_SKIP;
  assign is_comp_cs = alu_if.opcode == OP_COMP_ADD_CARRY;
  assign is_imm = alu_if.opcode[7:4] == OP_ADD_IMM_HI;
  assign sum_add_cs = {1'b0, alu_if.acc} + {1'b0, alu_if.mem}
    + {{ACC_W{1'b0}}, alu_if.carry};
  assign sum_comp_cs = {1'b0, ~alu_if.acc} + {1'b0, alu_if.mem}
    + {{ACC_W{1'b0}}, alu_if.carry};
  assign sum_imm = {1'b0, alu_if.acc} + {1'b0, imm};
  // ==========================================================
  // Carry and skip
  assign alu_if.res_carry = is_add_cs ? sum_add_cs[ACC_W] :
    is_comp_cs ? sum_comp_cs[ACC_W] :
    (alu_if.opcode == OP_CARRY_CLEAR) ? 1'b0 :
    (alu_if.opcode == OP_CARRY_SET) ? 1'b1 : alu_if.carry;
  assign alu_if.skip = (is_add_cs && sum_add_cs[ACC_W]) || (is_comp_cs && sum_comp_cs[ACC_W])
    || (is_imm && (imm != 4'h0) && sum_imm[ACC_W]);
  // ==========================================================
  // Accumulator result
  always_comb
  begin
    alu_if.res_acc = alu_if.acc;
    alu_if.known = 1'b1;
    if (is_imm)
    begin
      alu_if.res_acc = sum_imm[ACC_W-1:0];
    end
    else
    begin
      case (alu_if.opcode)
        OP_ADD_CARRY_SKIP: alu_if.res_acc = sum_add_cs[ACC_W-1:0];
        OP_COMP_ADD_CARRY: alu_if.res_acc = sum_comp_cs[ACC_W-1:0];
        OP_ADD: alu_if.res_acc = alu_if.acc + alu_if.mem;
        OP_ADD_TEN: alu_if.res_acc = alu_if.acc + ADD_TEN_VALUE;
        OP_CLEAR_ACC: alu_if.res_acc = ACC_RST;
        OP_COMP: alu_if.res_acc = ~alu_if.acc;
        OP_XOR: alu_if.res_acc = alu_if.acc ^ alu_if.mem;
        OP_NOP, OP_CARRY_CLEAR, OP_CARRY_SET: alu_if.res_acc = alu_if.acc;
        default: alu_if.known = 1'b0;
      endcase
    end
  end
endmodule : nau_alu

/* File: rtl/nau_ram.sv */
// Nibble data memory held in flip-flops
`timescale 1ns/100ps
module nau_ram (
  // Clock
  input wire logic core_clk_in,
  // Memory port
  nau_core_if.ram ram_if
);
  import nau_pkg::*;
  logic [ACC_W-1:0] mem_q [RAM_DEPTH];
  // ==========================================================
  // Storage, not cleared by reset
  for (genvar gi = 0; gi < RAM_DEPTH; gi++)
  begin : g_entry
    always_ff @(posedge core_clk_in)
    begin
      if (ram_if.ram_we && (ram_if.ram_idx == PTR_W'(gi)))
      begin
        mem_q[gi] <= ram_if.ram_wdata;
      end
    end
  end
  assign ram_if.ram_rdata = mem_q[ram_if.ram_idx];
endmodule : nau_ram

/* File: rtl/nau_core.sv */
// Arithmetic unit of a 4-bit core with Avalon-MM register access
`timescale 1ns/100ps
module nau_core #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Instruction stream from the sequencer
  input wire logic instr_valid_in,
  input wire logic [7:0] instr_in,
  // Avalon-MM slave
  input wire logic [nau_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [nau_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [nau_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core state
  output logic [nau_pkg::ACC_W-1:0] acc_out,
  output logic carry_out,
  output logic [nau_pkg::PTR_W-1:0] ptr_out,
  output logic skip_out
);
  import nau_pkg::*;

  nau_core_if cif ();

  logic [ACC_W-1:0] acc_q;
  logic carry_q;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_mask;
  logic [7:0] last_op_q;
  logic skip_q;
  logic skip_seen_q;
  logic badop_q;
  logic rd_done_q;
  logic [DATA_W-1:0] readdata_q;
  logic [DATA_W-1:0] rd_word;
  logic bus_wr_ok;
  logic bus_exec;
  logic exec_fire;
  logic [7:0] exec_op;
  logic wr_acc;
  logic wr_carry;
  logic wr_ptr;
  logic wr_ram;
  logic wr_status;

  // ==========================================================
  // Submodules
  nau_alu u_alu (
    .alu_if(cif.alu)
  );

  nau_ram u_ram (
    .core_clk_in(core_clk_in),
    .ram_if(cif.ram)
  );

  // ==========================================================
  // Bus decode
  // A write waits while the sequencer issues an instruction
  assign bus_wr_ok = avs_write_in && !instr_valid_in && avs_byteenable_in[0];
  assign bus_exec = bus_wr_ok && (avs_address_in == REG_OPCODE);
  assign wr_acc = bus_wr_ok && (avs_address_in == REG_ACC);
  assign wr_carry = bus_wr_ok && (avs_address_in == REG_CARRY);
  assign wr_ptr = bus_wr_ok && (avs_address_in == REG_PTR);
  assign wr_ram = bus_wr_ok && (avs_address_in == REG_RAM);
  assign wr_status = bus_wr_ok && (avs_address_in == REG_STATUS);
  assign avs_waitrequest_out = (avs_read_in && !rd_done_q)
    || (avs_write_in && instr_valid_in);

  // ==========================================================
  // Execution
  // Sequencer instruction has priority over a bus opcode write
  assign exec_fire = instr_valid_in || bus_exec;
  assign exec_op = instr_valid_in ? instr_in : avs_writedata_in[7:0];
  assign cif.opcode = exec_op;
  assign cif.acc = acc_q;
  assign cif.carry = carry_q;
  assign cif.mem = cif.ram_rdata;
  assign cif.ram_idx = ptr_q;
  assign cif.ram_we = wr_ram;
  assign cif.ram_wdata = avs_writedata_in[ACC_W-1:0];

  // ==========================================================
  // Accumulator
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      acc_q <= ACC_RST;
    end
    else if (exec_fire)
    begin
      acc_q <= cif.res_acc;
    end
    else if (wr_acc)
    begin
      acc_q <= avs_writedata_in[ACC_W-1:0];
    end
  end

  // ==========================================================
  // Carry flag
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      carry_q <= 1'b0;
    end
    else if (exec_fire)
    begin
      carry_q <= cif.res_carry;
    end
    else if (wr_carry)
    begin
      carry_q <= avs_writedata_in[0];
    end
  end

  // ==========================================================
  // RAM pointer, row above digit
  assign ptr_mask = LARGE_VARIANT ? PTR_MASK_LARGE : PTR_MASK_SMALL;

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      ptr_q <= PTR_RST;
    end
    else if (wr_ptr)
    begin
      ptr_q <= avs_writedata_in[PTR_W-1:0] & ptr_mask;
    end
  end

  // ==========================================================
  // Skip pulse and last opcode
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      skip_q <= 1'b0;
      last_op_q <= OPCODE_RST;
    end
    else
    begin
      skip_q <= exec_fire && cif.skip;
      if (exec_fire)
      begin
        last_op_q <= exec_op;
      end
    end
  end

  // ==========================================================
  // Sticky status, set beats clear
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      skip_seen_q <= 1'b0;
      badop_q <= 1'b0;
    end
    else
    begin
      if (exec_fire && cif.skip)
      begin
        skip_seen_q <= 1'b1;
      end
      else if (wr_status && avs_writedata_in[ST_SKIP_BIT])
      begin
        skip_seen_q <= 1'b0;
      end
      if (exec_fire && !cif.known)
      begin
        badop_q <= 1'b1;
      end
      else if (wr_status && avs_writedata_in[ST_BADOP_BIT])
      begin
        badop_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path, one wait cycle per read
  always_comb
  begin
    rd_word = '0;
    case (avs_address_in)
      REG_OPCODE: rd_word[7:0] = last_op_q;
      REG_ACC: rd_word[ACC_W-1:0] = acc_q;
      REG_CARRY: rd_word[0] = carry_q;
      REG_PTR: rd_word[PTR_W-1:0] = ptr_q;
      REG_RAM: rd_word[ACC_W-1:0] = cif.mem;
      REG_STATUS:
      begin
        rd_word[ST_SKIP_BIT] = skip_seen_q;
        rd_word[ST_BADOP_BIT] = badop_q;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_done_q <= 1'b0;
      readdata_q <= '0;
    end
    else
    begin
      rd_done_q <= avs_read_in && !rd_done_q;
      if (avs_read_in && !rd_done_q)
      begin
        readdata_q <= rd_word;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata_out = readdata_q;
  assign acc_out = acc_q;
  assign carry_out = carry_q;
  assign ptr_out = ptr_q;
  assign skip_out = skip_q;

  // ==========================================================
  // Checks
  logic [ACC_W:0] exp_add_cs;
  logic [ACC_W:0] exp_comp_cs;
  logic [ACC_W:0] exp_imm;
  assign exp_add_cs = {1'b0, acc_q} + {1'b0, cif.mem} + {{ACC_W{1'b0}}, carry_q};
  assign exp_comp_cs = {1'b0, ~acc_q} + {1'b0, cif.mem} + {{ACC_W{1'b0}}, carry_q};
  assign exp_imm = {1'b0, acc_q} + {1'b0, exec_op[ACC_W-1:0]};

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_ptr_width:
    assert property (wr_ptr |=> ptr_q == ($past(avs_writedata_in[PTR_W-1:0]) & ptr_mask))
    else $error("pointer width wrong");

  a_row_field:
    assert property (!LARGE_VARIANT |-> ptr_q[PTR_W-1:DIGIT_W+ROW_W_SMALL] == '0)
    else $error("row field too wide");

  a_digit_select:
    assert property (wr_ptr |=> cif.ram_idx[DIGIT_W-1:0]
      == $past(avs_writedata_in[DIGIT_W-1:0]))
    else $error("digit field wrong");

  a_mem_operand:
    assert property (wr_ram ##1 $stable(ptr_q) |-> cif.mem
      == $past(avs_writedata_in[ACC_W-1:0]))
    else $error("operand not addressed nibble");

  a_add_carry_result:
    assert property (exec_fire && exec_op == OP_ADD_CARRY_SKIP |=> {carry_q, acc_q}
      == $past(exp_add_cs) && skip_out == carry_q)
    else $error("add with carry wrong");

  a_imm_add_skip:
    assert property (exec_fire && exec_op[7:4] == OP_ADD_IMM_HI |=>
      acc_q == $past(exp_imm[ACC_W-1:0]) && $stable(carry_q)
      && skip_out == ($past(exp_imm[ACC_W]) && $past(exec_op[3:0]) != 4'h0))
    else $error("immediate add wrong");

  a_comp_add_result:
    assert property (exec_fire && exec_op == OP_COMP_ADD_CARRY |=> {carry_q, acc_q}
      == $past(exp_comp_cs) && skip_out == carry_q)
    else $error("complement add wrong");

  a_comp_result:
    assert property (exec_fire && exec_op == OP_COMP |=>
      acc_q == ~$past(acc_q) && $stable(carry_q) && !skip_out)
    else $error("complement wrong");

  a_xor_result:
    assert property (exec_fire && exec_op == OP_XOR |=>
      acc_q == ($past(acc_q) ^ $past(cif.mem)) && !skip_out)
    else $error("exclusive or wrong");

  a_add_plain:
    assert property (exec_fire && exec_op == OP_ADD |=>
      acc_q == $past(acc_q) + $past(cif.mem) && $stable(carry_q) && !skip_out)
    else $error("plain add wrong");

  a_add_ten:
    assert property (exec_fire && exec_op == OP_ADD_TEN |=>
      acc_q == $past(acc_q) + ADD_TEN_VALUE && $stable(carry_q) && !skip_out)
    else $error("add ten wrong");

  a_carry_ops:
    assert property (exec_fire && (exec_op == OP_CARRY_SET || exec_op == OP_CARRY_CLEAR) |=>
      carry_q == ($past(exec_op) == OP_CARRY_SET) && $stable(acc_q) && !skip_out)
    else $error("carry set or clear wrong");

  a_clear_acc:
    assert property (exec_fire && exec_op == OP_CLEAR_ACC |=> acc_q == ACC_RST && !skip_out)
    else $error("clear accumulator wrong");

  a_nop_keeps:
    assert property (exec_fire && exec_op == OP_NOP |=>
      $stable(acc_q) && $stable(carry_q) && !skip_out)
    else $error("no-operation changed state");

  a_imm_zero:
    assert property (exec_fire && exec_op == {OP_ADD_IMM_HI, 4'h0} |=>
      $stable(acc_q) && $stable(carry_q) && !skip_out)
    else $error("immediate zero add wrong");

  a_bad_opcode:
    assert property (exec_fire && !cif.known |=>
      $stable(acc_q) && $stable(carry_q) && badop_q && !skip_out)
    else $error("unknown opcode changed state");

  c_add_carry_skip: cover property (exec_fire && exec_op == OP_ADD_CARRY_SKIP ##1 skip_out);
  c_imm_zero: cover property (exec_fire && exec_op == {OP_ADD_IMM_HI, 4'h0});
  c_comp_add_skip: cover property (exec_fire && exec_op == OP_COMP_ADD_CARRY ##1 skip_out);
  c_bus_read: cover property (avs_read_in && avs_waitrequest_out ##1 !avs_waitrequest_out);
  c_bad_opcode: cover property (exec_fire && !cif.known);
endmodule : nau_core

/* File: sim/tb.sv */
// Self-checking bench for the nibble arithmetic unit
`timescale 1ns/100ps
module tb;
  import nau_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [7:0] instr_in = 8'h00;
  logic [ADDR_W-1:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [DATA_W-1:0] avs_writedata_in = 32'h0;
  logic [DATA_W-1:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [ACC_W-1:0] acc_out;
  logic carry_out;
  logic [PTR_W-1:0] ptr_out;
  logic [PTR_W-1:0] ptr_small;
  logic skip_out;
  int n_errors = 0;
  int num_checks = 0;
  // Opcodes swept against every operand set
  logic [7:0] ops [0:14] = '{8'h30, 8'h31, 8'h4A, 8'h10, 8'h40, 8'h02, 8'h00, 8'h44,
    8'h32, 8'h22, 8'h50, 8'h51, 8'h5F, 8'h57, 8'h5A};
  // Operand sets: pointer, accumulator, carry, nibble
  logic [15:0] sets [0:3] = '{{7'h5C, 4'h9, 1'b1, 4'h7}, {7'h00, 4'h0, 1'b0, 4'h0},
    {7'h7F, 4'hF, 1'b1, 4'hF}, {7'h23, 4'h5, 1'b0, 4'hA}};

  always #10 core_clk_in = ~core_clk_in;

  // ==========================================================
  // Devices under test
  nau_core #(.LARGE_VARIANT(1'b1)) dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .acc_out(acc_out),
    .carry_out(carry_out), .ptr_out(ptr_out), .skip_out(skip_out));
  nau_core #(.LARGE_VARIANT(1'b0)) dut_small (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(), .avs_waitrequest_out(),
    .acc_out(), .carry_out(), .ptr_out(ptr_small), .skip_out());

  // ==========================================================
  // Helpers
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    logic w;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_writedata_in <= d;
    w = 1'b1;
    q = 32'h0;
    for (i = 0; i < 20 && w !== 1'b0; i++)
    begin
      @(posedge core_clk_in);
      w = avs_waitrequest_out;
      q = avs_readdata_out;
    end
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (w !== 1'b0)
    begin
      check(32'h1, 32'h0);
      tally_and_finish();
    end
  endtask : bus

  // Issue one instruction; returns in the cycle after the executing edge
  task automatic exec_op(input logic [7:0] op);
    @(posedge core_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= op;
    @(posedge core_clk_in);
    instr_valid_in <= 1'b0;
    @(negedge core_clk_in);
  endtask : exec_op

  // Expected {skip, carry, acc}
  function automatic logic [5:0] model(input logic [7:0] op, input logic [3:0] a,
    input logic c, input logic [3:0] m);
    logic [4:0] s;
    logic [4:0] t;
    logic [4:0] u;
    s = {1'b0, a} + {1'b0, m} + {4'h0, c};
    t = {1'b0, ~a} + {1'b0, m} + {4'h0, c};
    u = {1'b0, a} + {1'b0, op[3:0]};
    case (op)
      8'h30: model = {s[4], s[4], s[3:0]};
      8'h31: model = {1'b0, c, a + m};
      8'h4A: model = {1'b0, c, a + 4'hA};
      8'h10: model = {t[4], t[4], t[3:0]};
      8'h40: model = {1'b0, c, ~a};
      8'h02: model = {1'b0, c, a ^ m};
      8'h00: model = {1'b0, c, 4'h0};
      8'h32: model = {1'b0, 1'b0, a};
      8'h22: model = {1'b0, 1'b1, a};
      default: model = (op[7:4] == 4'h5) ? {u[4] & (op[3:0] != 4'h0), c, u[3:0]} : {1'b0, c, a};
    endcase
  endfunction : model

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] rd;
    logic [6:0] p;
    logic [3:0] a;
    logic [3:0] m;
    logic c;
    logic [5:0] exp;
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    // Reset readback, unmapped place included
    bus(1'b0, REG_OPCODE, 32'h0, rd);
    check(rd, 32'h44);
    bus(1'b0, REG_ACC, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, REG_CARRY, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, REG_PTR, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 5'h18, 32'h0, rd);
    check(rd, 32'h0);
    $display("test reset_values done");
    // Row and digit selection of the operand nibble
    bus(1'b1, REG_PTR, 32'h15, rd);
    bus(1'b1, REG_RAM, 32'h3, rd);
    bus(1'b1, REG_PTR, 32'h25, rd);
    bus(1'b1, REG_RAM, 32'hC, rd);
    bus(1'b1, REG_PTR, 32'h16, rd);
    bus(1'b1, REG_RAM, 32'h6, rd);
    bus(1'b1, REG_PTR, 32'h15, rd);
    bus(1'b0, REG_RAM, 32'h0, rd);
    check(rd, 32'h3);
    bus(1'b1, REG_ACC, 32'h0, rd);
    exec_op(8'h02);
    check({28'h0, acc_out}, 32'h3);
    bus(1'b1, REG_PTR, 32'h25, rd);
    exec_op(8'h02);
    check({28'h0, acc_out}, 32'hF);
    bus(1'b1, REG_PTR, 32'h7F, rd);
    bus(1'b0, REG_PTR, 32'h0, rd);
    check(rd, 32'h7F);
    check({25'h0, ptr_out}, 32'h7F);
    check({25'h0, ptr_small}, 32'h3F);
    $display("test pointer_fields done");
    // Every opcode in ops against each operand set
    for (int k = 0; k < 4; k++)
    begin
      for (int j = 0; j < 15; j++)
      begin
        {p, a, c, m} = sets[k];
        bus(1'b1, REG_PTR, {25'h0, p}, rd);
        bus(1'b1, REG_RAM, {28'h0, m}, rd);
        bus(1'b1, REG_ACC, {28'h0, a}, rd);
        bus(1'b1, REG_CARRY, {31'h0, c}, rd);
        exp = model(ops[j], a, c, m);
        exec_op(ops[j]);
        check({27'h0, carry_out, acc_out}, {27'h0, exp[4:0]});
        check({31'h0, skip_out}, {31'h0, exp[5]});
        @(negedge core_clk_in);
        check({31'h0, skip_out}, 32'h0);
      end
    end
    $display("test opcode_sweep done");
    // Status flags and opcode issued over the bus
    bus(1'b1, REG_STATUS, 32'h3, rd);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, REG_ACC, 32'h7, rd);
    exec_op(8'h48);
    check({28'h0, acc_out}, 32'h7);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check(rd, 32'h2);
    bus(1'b1, REG_ACC, 32'hF, rd);
    exec_op(8'h51);
    check({30'h0, skip_out, acc_out == 4'h0}, 32'h3);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check(rd, 32'h3);
    bus(1'b1, REG_STATUS, 32'h3, rd);
    bus(1'b1, REG_OPCODE, 32'h32, rd);
    bus(1'b1, REG_OPCODE, 32'h22, rd);
    bus(1'b0, REG_CARRY, 32'h0, rd);
    check(rd, 32'h1);
    bus(1'b0, REG_OPCODE, 32'h0, rd);
    check(rd, 32'h22);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    $display("test status_and_bus_opcode done");
    tally_and_finish();
  end
endmodule : tb
